// file: hdl/jis_params.svh
/*
 * Register offsets, field positions, reset values and the threshold
 * encodings of the codec interrupt and status block.
 * Assumes byte addressing on a 32-bit Wishbone bus.
 */
`ifndef JIS_PARAMS_SVH
`define JIS_PARAMS_SVH

// word indexes, not byte addresses: byte address is the low ten index bits times four
`define JIS_IDX_RAW        12'h984
`define JIS_IDX_IEN        12'h986
`define JIS_IDX_RSVD_A     12'h988
`define JIS_IDX_START      12'h98a
`define JIS_IDX_FIFO_SET   12'h9a0
`define JIS_IDX_MASKED     12'h982
`define JIS_IDX_SIZE_LIM   12'h9b0
`define JIS_IDX_SIZE_RES   12'h9b4

`define JIS_RAW_RESET      16'h8180
`define JIS_RAW_RSVD_MASK  16'h8080
`define JIS_IEN_MASK       16'h0f37

`define JIS_B_FILE_OUT     14
`define JIS_B_SIZE_VIOL    11
`define JIS_B_THR_TRIG     10
`define JIS_B_FULL         9
`define JIS_B_EMPTY        8
`define JIS_B_DEC_DONE     5
`define JIS_B_MARKER       4
`define JIS_B_LB_OVF       2
`define JIS_B_CODEC_IRQ    1
`define JIS_B_LB_IRQ       0

`define JIS_FS_THR_LO      4
`define JIS_FS_CLEAR       2
`define JIS_FS_DIR         1

`define JIS_FIFO_4BYTES    4
`define JIS_ERRDET_FIRST   2'h1

`endif

// file: hdl/jis_pkg.sv
/*
 * Types of the codec interrupt and status block.
 * Assumes jis_params.svh holds the numeric constants.
 */
package jis_pkg;
	typedef enum logic [1:0] {
		JIS_MODE_IDLE    = 2'b00,
		JIS_MODE_ENCODE  = 2'b01,
		JIS_MODE_BYPASS  = 2'b10,
		JIS_MODE_DECODE  = 2'b11
	} jis_mode_t;

	typedef enum logic [1:0] {
		JIS_CAP_IDLE  = 2'b00,
		JIS_CAP_ARMED = 2'b01,
		JIS_CAP_RUN   = 2'b10,
		JIS_CAP_LAST  = 2'b11
	} jis_cap_t;

	// events and levels from the codec core
	typedef struct packed {
		logic        file_out;
		logic        dec_done;
		logic        dec_error;
		logic        marker_read;
		logic        lb_overflow;
		logic        codec_irq;
		logic        codec_status_read;
		logic        lb_irq_pending;
		logic        frame_start;
		logic        frame_end;
		logic        module_reset;
		logic        fifo_direction;
		logic [1:0]  error_detect;
		logic [2:0]  module_mode;
		jis_mode_t   op_mode;
	} jis_core_t;

	// controls to the codec core
	typedef struct packed {
		logic        capture;
		logic        fifo_clear;
	} jis_ctrl_t;
endpackage : jis_pkg

// file: hdl/jis_status.sv
/*
 * Raw status, interrupt enables, start/stop control and FIFO setting
 * of the image codec, as a classic Wishbone slave with 32-bit data.
 * Assumes the codec core drives jis_core_t synchronously to clk_i and
 * that the FIFO level arrives as a byte count on the same clock.
 */
// Implementation choice: register access over Wishbone.
// Notes on behaviour
// RULE1: bit 14 shows encoded output in progress
// RULE2: bits 13-12 report FIFO fill level
// RULE3: size violation sets regardless of enable
// RULE4: violation clears by write one after end
// RULE5: threshold flag sets on level, sticky
// RULE6: full flag sets while full, sticky
// RULE7: empty flag sticky; FIFO clear leaves it
// RULE8: decode done sets unless error mode 01
// RULE9: marker sets only while enabled; disable clears
// RULE10: overflow flag cleared only by module reset
// RULE11: codec interrupt cleared by status read
// RULE12: line buffer flag follows pending requests
// RULE13: enable bits gate matching flags
// RULE14: software keeps line buffer enable usually clear
// RULE15: encode start captures one frame, stops
// RULE16: bypass captures until stop, frame end
// RULE17: start/stop ignored when decoding
// RULE18: threshold field selects trigger condition
// RULE19: 00 never, 01 four bytes, quarter, half
// RULE20: FIFO clear write one empties the FIFO
// RULE21: masked view gated, write one clears
// RULE22: interrupt output on any enabled flag
`timescale 1ns/10ps
`include "jis_params.svh"

module jis_status #(
	parameter int FIFO_BYTES = 4096,
	parameter int LVL_W      = 16
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [11:0]       adr_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	input  wire logic              we_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	output logic                   ack_o,
	input  wire jis_pkg::jis_core_t core_i,
	input  wire logic [LVL_W-1:0]  fifo_level_i,
	input  wire logic [23:0]       size_result_i,
	output jis_pkg::jis_ctrl_t     ctrl_o,
	output logic                   irq_o
);
	import jis_pkg::*;

	// level compares need the full size to fit the level port
	if (FIFO_BYTES < 16 || FIFO_BYTES >= (1 << LVL_W)) begin : g_bad_fifo
		$error("jis_status: FIFO_BYTES does not fit LVL_W");
	end

	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(FIFO_BYTES);
	localparam logic [LVL_W-1:0] LVL_QTR  = LVL_W'(FIFO_BYTES / 4);
	localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(FIFO_BYTES / 2);
	localparam logic [LVL_W-1:0] LVL_4B   = LVL_W'(`JIS_FIFO_4BYTES);

	logic [15:0] raw;
	logic [15:0] ien;
	logic [1:0]  thr_sel;
	logic [23:0] size_limit;
	logic        start_bit;
	jis_cap_t    cap_state;

	// bus decode: word index is byte address divided by four
	logic        req;
	logic        wr;
	logic        rd;
	logic [9:0]  idx;
	logic [11:0] idx12;
	logic        lo_ok;
	assign req   = cyc_i && stb_i && !ack_o;
	assign wr    = req && we_i;
	assign rd    = req && !we_i;
	assign idx   = adr_i[11:2];
	// only ten index bits arrive; all words sit in the 0x8xx-0xbxx range
	assign idx12 = {2'b10, idx};
	assign lo_ok = sel_i[0];

	logic wr_masked;
	logic wr_ien;
	logic wr_start;
	logic wr_fset;
	logic wr_lim;
	logic [15:0] wdat;
	assign wdat      = dat_i[15:0];
	assign wr_masked = wr && lo_ok && idx12 == `JIS_IDX_MASKED;
	assign wr_ien    = wr && lo_ok && idx12 == `JIS_IDX_IEN;
	assign wr_start  = wr && lo_ok && idx12 == `JIS_IDX_START;
	assign wr_fset   = wr && lo_ok && idx12 == `JIS_IDX_FIFO_SET;
	assign wr_lim    = wr && lo_ok && idx12 == `JIS_IDX_SIZE_LIM;

	// level conditions
	logic lvl_empty;
	logic lvl_full;
	logic lvl_4b;
	logic lvl_qtr;
	logic lvl_half;
	logic trig_cond;
	logic viol_cond;
	logic [1:0] lvl_code;
	assign lvl_empty = fifo_level_i == '0;
	assign lvl_full  = fifo_level_i >= LVL_FULL;
	assign lvl_4b    = fifo_level_i > LVL_4B;
	assign lvl_qtr   = fifo_level_i > LVL_QTR;
	assign lvl_half  = fifo_level_i > LVL_HALF;
	assign lvl_code  = lvl_half ? 2'h3 : lvl_qtr ? 2'h2 :
		lvl_4b ? 2'h1 : 2'h0; // [RULE2]
	assign viol_cond = size_limit != '0 && size_result_i > size_limit;

	always_comb begin
		case (thr_sel) // [RULE18]
			2'h0: trig_cond = 1'b0; // [RULE19]
			2'h1: trig_cond = fifo_level_i >= LVL_4B;
			2'h2: trig_cond = lvl_qtr;
			2'h3: trig_cond = lvl_half;
			default: trig_cond = 1'b0;
		endcase
	end

	// write-one clears act only once the cause has gone; set wins
	logic [15:0] w1c;
	assign w1c = wr_masked ? wdat : 16'h0000;
	logic mrst;
	assign mrst = core_i.module_reset;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw <= `JIS_RAW_RESET;
		end else begin
			raw[15]                <= 1'b1;
			raw[`JIS_B_FILE_OUT]   <= core_i.file_out; // [RULE1]
			raw[13:12]             <= lvl_code; // [RULE2]
			if (viol_cond) // [RULE3]
				raw[`JIS_B_SIZE_VIOL] <= 1'b1;
			else if (mrst || w1c[`JIS_B_SIZE_VIOL]) // [RULE4] [RULE21]
				raw[`JIS_B_SIZE_VIOL] <= 1'b0;
			if (trig_cond) // [RULE5]
				raw[`JIS_B_THR_TRIG] <= 1'b1;
			else if (mrst || w1c[`JIS_B_THR_TRIG])
				raw[`JIS_B_THR_TRIG] <= 1'b0;
			if (lvl_full) // [RULE6]
				raw[`JIS_B_FULL] <= 1'b1;
			else if (mrst || w1c[`JIS_B_FULL])
				raw[`JIS_B_FULL] <= 1'b0;
			// fifo clear is deliberately not a term here
			if (lvl_empty) // [RULE7]
				raw[`JIS_B_EMPTY] <= 1'b1;
			else if (mrst || w1c[`JIS_B_EMPTY])
				raw[`JIS_B_EMPTY] <= 1'b0;
			raw[7:6]               <= 2'b10;
			if (core_i.dec_done && !(core_i.dec_error &&
				core_i.error_detect == `JIS_ERRDET_FIRST)) // [RULE8]
				raw[`JIS_B_DEC_DONE] <= 1'b1;
			else if (mrst || w1c[`JIS_B_DEC_DONE])
				raw[`JIS_B_DEC_DONE] <= 1'b0;
			if (!ien[`JIS_B_MARKER]) // [RULE9]
				raw[`JIS_B_MARKER] <= 1'b0;
			else if (core_i.marker_read)
				raw[`JIS_B_MARKER] <= 1'b1;
			raw[3]                 <= 1'b0;
			if (core_i.lb_overflow) // [RULE10]
				raw[`JIS_B_LB_OVF] <= 1'b1;
			else if (mrst)
				raw[`JIS_B_LB_OVF] <= 1'b0;
			if (core_i.codec_irq) // [RULE11]
				raw[`JIS_B_CODEC_IRQ] <= 1'b1;
			else if (core_i.codec_status_read)
				raw[`JIS_B_CODEC_IRQ] <= 1'b0;
			raw[`JIS_B_LB_IRQ] <= core_i.lb_irq_pending &&
				core_i.module_mode != 3'b000; // [RULE12]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ien <= 16'h0000;
		else if (wr_ien)
			ien <= wdat & `JIS_IEN_MASK; // [RULE13]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_sel           <= 2'h0;
			ctrl_o.fifo_clear <= 1'b0;
		end else begin
			if (wr_fset)
				thr_sel <= wdat[`JIS_FS_THR_LO +: 2]; // [RULE18]
			// one-cycle clear pulse; zero written does nothing
			ctrl_o.fifo_clear <= wr_fset && wdat[`JIS_FS_CLEAR]; // [RULE20]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			size_limit <= 24'h000000;
		else if (wr_lim)
			size_limit <= dat_i[23:0];
	end

	// capture sequencer; start bit only observed in encode and bypass
	logic cap_mode;
	assign cap_mode = core_i.op_mode == JIS_MODE_ENCODE ||
		core_i.op_mode == JIS_MODE_BYPASS; // [RULE17]

	always_ff @(posedge clk_i) begin
		if (rst_i)
			start_bit <= 1'b0;
		else if (wr_start)
			start_bit <= wdat[0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || mrst || !cap_mode) begin
			cap_state      <= JIS_CAP_IDLE;
			ctrl_o.capture <= 1'b0;
		end else begin
			case (cap_state)
				JIS_CAP_IDLE: begin
					if (wr_start && wdat[0])
						cap_state <= JIS_CAP_ARMED;
				end
				JIS_CAP_ARMED: begin
					if (core_i.frame_start) begin // [RULE15] [RULE16]
						cap_state      <= JIS_CAP_RUN;
						ctrl_o.capture <= 1'b1;
					end else if (wr_start && !wdat[0] &&
						core_i.op_mode == JIS_MODE_BYPASS) begin
						cap_state <= JIS_CAP_IDLE;
					end
				end
				JIS_CAP_RUN: begin
					// encode takes one frame only
					if (core_i.op_mode == JIS_MODE_ENCODE &&
						core_i.frame_end) begin // [RULE15]
						cap_state      <= JIS_CAP_IDLE;
						ctrl_o.capture <= 1'b0;
					end else if (!start_bit || (wr_start && !wdat[0]))
						cap_state <= JIS_CAP_LAST; // [RULE16]
				end
				JIS_CAP_LAST: begin
					if (core_i.frame_end) begin // [RULE16]
						cap_state      <= JIS_CAP_IDLE;
						ctrl_o.capture <= 1'b0;
					end
				end
				default: begin
					cap_state      <= JIS_CAP_IDLE;
					ctrl_o.capture <= 1'b0;
				end
			endcase
		end
	end

	// masked view and interrupt output
	logic [15:0] masked;
	// file-out and level bits are status, shown unmasked in both views
	assign masked = (raw & ien) | {1'b0, raw[14:12], 12'h000}; // [RULE21] [RULE1]

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(raw & ien & `JIS_IEN_MASK); // [RULE22] [RULE13]
	end

	// read mux; unmapped and write-only words read as zero
	logic [15:0] rdat;
	always_comb begin
		case (idx12)
			`JIS_IDX_RAW:      rdat = raw;
			`JIS_IDX_MASKED:   rdat = masked;
			`JIS_IDX_IEN:      rdat = ien;
			`JIS_IDX_FIFO_SET: rdat = {10'h000, thr_sel, 1'b0, 1'b0,
				core_i.fifo_direction, 1'b0};
			`JIS_IDX_SIZE_LIM: rdat = size_limit[15:0];
			default:           rdat = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			if (rd)
				dat_o <= (idx12 == `JIS_IDX_SIZE_LIM) ?
					{8'h00, size_limit} : {16'h0000, rdat};
		end
	end

	a_viol_sets: assert property (@(posedge clk_i) // [RULE3]
		disable iff (rst_i)
		viol_cond |=> raw[`JIS_B_SIZE_VIOL])
		else $error("size violation flag not set");
	a_viol_holds: assert property (@(posedge clk_i) // [RULE4]
		disable iff (rst_i)
		raw[`JIS_B_SIZE_VIOL] && viol_cond |=> raw[`JIS_B_SIZE_VIOL])
		else $error("violation flag cleared while violating");
	a_thr_sets: assert property (@(posedge clk_i) // [RULE5]
		disable iff (rst_i)
		trig_cond |=> raw[`JIS_B_THR_TRIG])
		else $error("threshold flag not set");
	a_full_sets: assert property (@(posedge clk_i) // [RULE6]
		disable iff (rst_i)
		lvl_full |=> raw[`JIS_B_FULL])
		else $error("full flag not set");
	a_empty_clrfree: assert property (@(posedge clk_i) // [RULE7]
		disable iff (rst_i)
		raw[`JIS_B_EMPTY] && !mrst && !w1c[`JIS_B_EMPTY]
		|=> raw[`JIS_B_EMPTY])
		else $error("empty flag lost without clear");
	a_dec_err_blk: assert property (@(posedge clk_i) // [RULE8]
		disable iff (rst_i)
		core_i.dec_done && core_i.dec_error &&
		core_i.error_detect == `JIS_ERRDET_FIRST &&
		!raw[`JIS_B_DEC_DONE] |=> !raw[`JIS_B_DEC_DONE])
		else $error("decode done set despite error");
	a_marker_gate: assert property (@(posedge clk_i) // [RULE9]
		disable iff (rst_i)
		!ien[`JIS_B_MARKER] |=> !raw[`JIS_B_MARKER])
		else $error("marker flag set while disabled");
	a_ovf_sticky: assert property (@(posedge clk_i) // [RULE10]
		disable iff (rst_i)
		raw[`JIS_B_LB_OVF] && !mrst |=> raw[`JIS_B_LB_OVF])
		else $error("overflow flag cleared without reset");
	a_codec_sets: assert property (@(posedge clk_i) // [RULE11]
		disable iff (rst_i)
		core_i.codec_irq |=> raw[`JIS_B_CODEC_IRQ])
		else $error("codec interrupt flag not set");
	a_level_code: assert property (@(posedge clk_i) // [RULE2]
		disable iff (rst_i)
		lvl_empty |=> raw[13:12] == 2'h0)
		else $error("level code wrong when empty");
	a_irq_out: assert property (@(posedge clk_i) // [RULE22]
		disable iff (rst_i)
		|(raw & ien) |=> irq_o)
		else $error("interrupt output missing");
	a_no_cap_dec: assert property (@(posedge clk_i) // [RULE17]
		disable iff (rst_i)
		core_i.op_mode == JIS_MODE_DECODE |=> !ctrl_o.capture)
		else $error("capture active in decode");
	a_ack_pulse: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held two cycles");

	c_viol: cover property (@(posedge clk_i) raw[`JIS_B_SIZE_VIOL]);
	c_irq: cover property (@(posedge clk_i) irq_o);
	c_cap: cover property (@(posedge clk_i) ctrl_o.capture);
	c_w1c: cover property (@(posedge clk_i) wr_masked && w1c[`JIS_B_FULL]);
endmodule : jis_status

// file: dv/jis_status_bench.sv
/* self-checking bench for jis_status: flags, enables, start/stop, fifo.
   assumes the design carries its own assertions and decodes adr_i[11:2] */
`timescale 1ns/10ps
`include "jis_params.svh"
module jis_status_bench;
	import jis_pkg::*;
	localparam int FB = 64;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        we_i, cyc_i, stb_i, ack_o, irq_o;
	logic [11:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0]  sel_i;
	logic [15:0] fifo_level_i, q, ien;
	logic [23:0] size_result_i;
	jis_core_t   core_i;
	jis_ctrl_t   ctrl_o;
	int          fails, samples_checked, cyc_cnt, clr_seen;
	// each threshold pair straddles its boundary
	int          lv[8] = '{0, 4, 4, 3, 16, 17, 32, 33};

	// small fifo so the quarter and half marks are cheap to reach
	jis_status #(.FIFO_BYTES(FB)) u_jis_status (.clk_i(clk_i),
		.rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .core_i(core_i), .fifo_level_i(fifo_level_i),
		.size_result_i(size_result_i), .ctrl_o(ctrl_o), .irq_o(irq_o));

	always #4 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (ctrl_o.fifo_clear === 1'b1)
			clr_seen++;
		if (cyc_cnt == 20000) begin
			fails++;
			wrap_up();
		end
	end

	function automatic logic [15:0] fifo_exp(logic [1:0] t, int l);
		logic [1:0] st;
		logic       tr;
		st = l > FB / 2 ? 2'h3 : l > FB / 4 ? 2'h2 : l > 4 ? 2'h1 : 2'h0;
		tr = (t == 2'h1 && l >= 4) || (t == 2'h2 && l > FB / 4) ||
			(t == 2'h3 && l > FB / 2);
		return {2'h0, st, 1'b0, tr, l >= FB, l == 0, 8'h0};
	endfunction : fifo_exp

	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (e !== s) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// one classic cycle; released only at the edge that saw ack
	task automatic wb(logic w, logic [11:0] idx, logic [15:0] d,
		logic [3:0] s = 4'hf);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= {idx[9:0], 2'b00};
		we_i  <= w;
		dat_i <= {16'h0, d};
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task automatic rd(logic [11:0] idx);
		wb(1'b0, idx, 16'h0);
	endtask : rd

	task automatic raw_chk(string n, logic [15:0] m, logic [15:0] e);
		tick(2);
		rd(`JIS_IDX_RAW);
		chk(n, e & m, q & m);
	endtask : raw_chk

	task automatic frm(logic s);
		@(posedge clk_i);
		core_i.frame_start <= s;
		core_i.frame_end   <= ~s;
		@(posedge clk_i);
		core_i.frame_start <= 1'b0;
		core_i.frame_end   <= 1'b0;
		tick(2);
	endtask : frm

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	initial begin
		fails = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		clr_seen = 0;
		void'($urandom(32'h6c41e482));
		core_i = '0;
		fifo_level_i = 16'h0;
		size_result_i = 24'h0;
		adr_i = 12'h0;
		dat_i = 32'h0;
		sel_i = 4'h0;
		we_i = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`JIS_IDX_RAW);
		chk("raw reset", `JIS_RAW_RESET, q);
		rd(`JIS_IDX_RSVD_A);
		chk("reserved", 16'h0, q);
		ien = 16'($urandom) & 16'hfffe;
		wb(1'b1, `JIS_IDX_IEN, ien);
		wb(1'b1, `JIS_IDX_IEN, ~ien, 4'he);
		rd(`JIS_IDX_IEN);
		chk("enable", ien & `JIS_IEN_MASK, q);
		$display("test registers done");
		for (int i = 0; i < 24; i++) begin
			int          l;
			logic [1:0]  t;
			logic [15:0] e;
			l = i < 8 ? lv[i] : i == 8 ? FB : $urandom_range(FB, 5);
			t = i < 8 ? 2'(i / 2) : 2'($urandom);
			fifo_level_i <= 16'h0;
			wb(1'b1, `JIS_IDX_FIFO_SET, {10'h0, t, 4'h0});
			tick(2);
			wb(1'b1, `JIS_IDX_MASKED, 16'h0f00);
			fifo_level_i <= 16'(l);
			tick(2);
			wb(1'b1, `JIS_IDX_MASKED, 16'h0100);
			raw_chk("fifo flags", 16'h3f00, fifo_exp(t, l));
			rd(`JIS_IDX_MASKED);
			e = fifo_exp(t, l) & (ien | 16'h3000);
			chk("masked", e & 16'h3f00, q & 16'h3f00);
			rd(`JIS_IDX_FIFO_SET);
			chk("fifo set", {10'h0, t, 4'h0}, q);
			tick(2);
			chk("irq", {15'h0, |(fifo_exp(t, l) & ien & 16'h0700)}, {15'h0, irq_o});
		end
		fifo_level_i <= 16'h8;
		wb(1'b1, `JIS_IDX_MASKED, 16'h0100);
		clr_seen = 0;
		wb(1'b1, `JIS_IDX_FIFO_SET, 16'h0000);
		wb(1'b1, `JIS_IDX_FIFO_SET, 16'h0004);
		tick(2);
		chk("fifo clear", 16'h1, 16'(clr_seen));
		raw_chk("empty kept", 16'h0100, 16'h0);
		$display("test fifo done");
		wb(1'b1, `JIS_IDX_IEN, 16'h0);
		size_result_i <= 24'd101;
		wb(1'b1, `JIS_IDX_SIZE_LIM, 16'd100);
		raw_chk("viol set", 16'h0800, 16'h0800);
		wb(1'b1, `JIS_IDX_MASKED, 16'h0800);
		raw_chk("viol held", 16'h0800, 16'h0800);
		size_result_i <= 24'd50;
		wb(1'b1, `JIS_IDX_MASKED, 16'h0800);
		raw_chk("viol clear", 16'h0800, 16'h0);
		core_i.error_detect <= `JIS_ERRDET_FIRST;
		core_i.dec_error <= 1'b1;
		@(posedge clk_i) core_i.dec_done <= 1'b1;
		@(posedge clk_i) core_i.dec_done <= 1'b0;
		raw_chk("done err", 16'h0020, 16'h0);
		core_i.dec_error <= 1'b0;
		@(posedge clk_i) core_i.dec_done <= 1'b1;
		@(posedge clk_i) core_i.dec_done <= 1'b0;
		raw_chk("done set", 16'h0020, 16'h0020);
		wb(1'b1, `JIS_IDX_MASKED, 16'h0020);
		raw_chk("done clear", 16'h0020, 16'h0);
		@(posedge clk_i) core_i.marker_read <= 1'b1;
		@(posedge clk_i) core_i.marker_read <= 1'b0;
		raw_chk("marker off", 16'h0010, 16'h0);
		wb(1'b1, `JIS_IDX_IEN, 16'h0010);
		@(posedge clk_i) core_i.marker_read <= 1'b1;
		@(posedge clk_i) core_i.marker_read <= 1'b0;
		raw_chk("marker set", 16'h0010, 16'h0010);
		wb(1'b1, `JIS_IDX_IEN, 16'h0);
		raw_chk("marker clear", 16'h0010, 16'h0);
		@(posedge clk_i) core_i.lb_overflow <= 1'b1;
		@(posedge clk_i) core_i.lb_overflow <= 1'b0;
		wb(1'b1, `JIS_IDX_MASKED, 16'h0004);
		raw_chk("ovf held", 16'h0004, 16'h0004);
		@(posedge clk_i) core_i.module_reset <= 1'b1;
		@(posedge clk_i) core_i.module_reset <= 1'b0;
		raw_chk("ovf clear", 16'h0004, 16'h0);
		@(posedge clk_i) core_i.codec_irq <= 1'b1;
		@(posedge clk_i) core_i.codec_irq <= 1'b0;
		raw_chk("codec set", 16'h0002, 16'h0002);
		@(posedge clk_i) core_i.codec_status_read <= 1'b1;
		@(posedge clk_i) core_i.codec_status_read <= 1'b0;
		raw_chk("codec clear", 16'h0002, 16'h0);
		core_i.lb_irq_pending <= 1'b1;
		raw_chk("lb mode0", 16'h0001, 16'h0);
		core_i.module_mode <= 3'h5;
		raw_chk("lb set", 16'h0001, 16'h0001);
		core_i.lb_irq_pending <= 1'b0;
		raw_chk("lb clear", 16'h0001, 16'h0);
		core_i.file_out <= 1'b1;
		raw_chk("file out", 16'h4000, 16'h4000);
		rd(`JIS_IDX_MASKED);
		chk("file masked", 16'h4000, q & 16'h4000);
		core_i.file_out <= 1'b0;
		raw_chk("file idle", 16'h4000, 16'h0);
		$display("test flags done");
		core_i.op_mode <= JIS_MODE_ENCODE;
		wb(1'b1, `JIS_IDX_START, 16'h1);
		frm(1'b1);
		chk("enc run", 16'h1, {15'h0, ctrl_o.capture});
		frm(1'b0);
		frm(1'b1);
		chk("enc once", 16'h0, {15'h0, ctrl_o.capture});
		core_i.op_mode <= JIS_MODE_BYPASS;
		wb(1'b1, `JIS_IDX_START, 16'h1);
		tick(2);
		chk("byp wait", 16'h0, {15'h0, ctrl_o.capture});
		frm(1'b1);
		frm(1'b0);
		frm(1'b1);
		chk("byp run", 16'h1, {15'h0, ctrl_o.capture});
		wb(1'b1, `JIS_IDX_START, 16'h0);
		tick(2);
		chk("byp tail", 16'h1, {15'h0, ctrl_o.capture});
		frm(1'b0);
		chk("byp stop", 16'h0, {15'h0, ctrl_o.capture});
		core_i.op_mode <= JIS_MODE_DECODE;
		wb(1'b1, `JIS_IDX_START, 16'h1);
		frm(1'b1);
		chk("dec idle", 16'h0, {15'h0, ctrl_o.capture});
		$display("test capture done");
		wrap_up();
	end
endmodule : jis_status_bench
